// ===== mpm_meter.sv
`timescale 1ns/1ps
// ****************************************
// Upstream metering model
// ****************************************
module mpm_meter (
  input wire logic clock,
  output mpm_pkg::mpm_meas_t meas
);
  // Index 4 imbalance down to 0 frequency
  logic [4:0][15:0] val_q = {16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0032};
  assign meas = val_q;
  // New reading lands just after an edge
  task automatic put(input int q, input logic [15:0] v);
    @(posedge clock);
    val_q[4 - q] <= v;
  endtask
endmodule

// ===== mpm_monitor.sv
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "mpm_params.svh"
module mpm_monitor #(
  parameter int TICK_CYCLES = `MPM_TICK_NS / `MPM_CLK_NS,
  parameter int HOUR_TICKS = `MPM_HOUR_TICKS
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [5:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire mpm_pkg::mpm_meas_t meas,
  input wire logic motor_running,
  input wire logic motor_start,
  input wire logic open_gate_trip,
  output logic [15:0] fault,
  output logic [15:0] alarm,
  output logic restart
);
  localparam mpm_pkg::mpm_st_t ST_RST = '{
    lvl: {`MPM_DEF_THD_LVL, `MPM_DEF_THD_LVL, `MPM_DEF_THD_LVL,
      `MPM_DEF_THD_LVL, `MPM_DEF_JAM_LVL, `MPM_DEF_JAM_LVL,
      `MPM_DEF_IMB_LVL, `MPM_DEF_IMB_LVL},
    dly: {{6{`MPM_DEF_SHORT_DLY}}, `MPM_DEF_IMB_DLY, `MPM_DEF_IMB_DLY},
    flim: {`MPM_DEF_FLO, `MPM_DEF_FHI, `MPM_DEF_FLO, `MPM_DEF_FHI},
    mfe: 16'h0000,
    mae: 16'h0000,
    sfe: `MPM_DEF_SFE,
    sae: 16'h0000,
    rse: 16'h0000,
    pmh: `MPM_DEF_PMH,
    pms: `MPM_DEF_PMS,
    sph: `MPM_DEF_SPH,
    ratt: 16'h0000,
    rdly: 16'h0000,
    fault: 16'h0000,
    alarm: 16'h0000,
    hrs_rem: `MPM_DEF_PMH,
    sts_rem: `MPM_DEF_PMS,
    run_ticks: 16'h0000,
    win: '0,
    rs_st: mpm_pkg::MPM_RS_IDLE,
    rs_cnt: 3'h0,
    rs_tmr: 16'h0000,
    rdata: 16'h0000,
    restart: 1'b0
  };

  mpm_pkg::mpm_st_t q;
  mpm_pkg::mpm_st_t d;
  logic tick;
  logic [7:0] qv;
  logic [7:0] cond;
  logic [15:0] set;
  logic [15:0] clr;
  logic [15:0] al;
  logic [15:0] rmask;
  logic [3:0] nwin;
  logic placed;
  logic blocked;
  logic rs_ok;
  logic hour_end;

  // ****************************************
  // Time base and qualification timers
  // ****************************************
  mpm_tick_div #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clock(clock),
    .rst_b(rst_b),
    .tick(tick)
  );

  // Even index is the fault path, odd the alarm path
  always_comb begin
    cond[0] = meas.imbal > q.lvl[0];
    cond[1] = meas.imbal > q.lvl[1];
    cond[2] = meas.peak > q.lvl[2];
    cond[3] = meas.peak > q.lvl[3];
    cond[4] = meas.thd_v > q.lvl[4];
    cond[5] = meas.thd_v > q.lvl[5];
    cond[6] = meas.thd_i > q.lvl[6];
    cond[7] = meas.thd_i > q.lvl[7];
  end

  for (genvar g = 0; g < 8; g++) begin : g_qual
    mpm_qual_timer u_qual (
      .clock(clock),
      .rst_b(rst_b),
      .tick(tick),
      .cond(cond[g]),
      .dly(q.dly[g]),
      .qual(qv[g])
    );
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    d.restart = 1'b0;
    d.rdata = 16'h0000;
    set = 16'h0000;
    clr = 16'h0000;
    al = 16'h0000;
    nwin = 4'h0;
    placed = 1'b0;
    hour_end = 1'b0;

    // Register writes
    if (wr) begin
      if (addr[5:4] == `MPM_A_THR_RGN) begin
        if (addr[0]) begin
          d.dly[addr[3:1]] = wdata;
        end else begin
          d.lvl[addr[3:1]] = wdata;
        end
      end else if (addr[5:2] == `MPM_A_FLIM_RGN) begin
        d.flim[addr[1:0]] = wdata;
      end else begin
        case (addr)
          `MPM_A_MFE: d.mfe = wdata;
          `MPM_A_MAE: d.mae = wdata;
          `MPM_A_SFE: d.sfe = wdata;
          `MPM_A_SAE: d.sae = wdata;
          `MPM_A_RSE: d.rse = wdata;
          `MPM_A_PMH: begin
            d.pmh = wdata;
            d.hrs_rem = wdata;
          end
          `MPM_A_PMS: begin
            d.pms = wdata;
            d.sts_rem = wdata;
          end
          `MPM_A_SPH: d.sph = wdata;
          `MPM_A_RATT: d.ratt = wdata;
          `MPM_A_RDLY: d.rdly = wdata;
          `MPM_A_CTRL: begin
            if (wdata[`MPM_C_RCLR]) begin
              d.rs_cnt = 3'h0;
            end
            if (wdata[`MPM_C_HLD]) begin
              d.hrs_rem = q.pmh;
            end
            if (wdata[`MPM_C_SLD]) begin
              d.sts_rem = q.pms;
            end
          end
          `MPM_A_FAULT: clr = wdata;
          default: ;
        endcase
      end
    end

    // Sliding one-hour start window
    for (int i = 0; i < `MPM_WIN_SLOTS; i++) begin
      if (q.win[i] != 16'h0000) begin
        nwin = nwin + 4'h1;
        if (tick) begin
          d.win[i] = q.win[i] - 16'h0001;
        end
      end
    end
    blocked = motor_start && ({12'h000, nwin} >= q.sph);
    for (int i = 0; i < `MPM_WIN_SLOTS; i++) begin
      if (motor_start && !blocked && !placed && q.win[i] == 16'h0000) begin
        d.win[i] = 16'(HOUR_TICKS);
        placed = 1'b1;
      end
    end

    // Maintenance countdowns
    if (tick && motor_running) begin
      hour_end = q.run_ticks == 16'(HOUR_TICKS - 1);
      if (hour_end) begin
        d.run_ticks = 16'h0000;
        if (q.hrs_rem != 16'h0000 && !(wr && addr == `MPM_A_PMH)
            && !(wr && addr == `MPM_A_CTRL && wdata[`MPM_C_HLD])) begin
          d.hrs_rem = q.hrs_rem - 16'h0001;
        end
      end else begin
        d.run_ticks = q.run_ticks + 16'h0001;
      end
    end
    if (motor_start && !blocked && q.sts_rem != 16'h0000
        && !(wr && addr == `MPM_A_PMS)
        && !(wr && addr == `MPM_A_CTRL && wdata[`MPM_C_SLD])) begin
      d.sts_rem = q.sts_rem - 16'h0001;
    end

    // Fault detection, latched
    set[`MPM_B_IMB] = qv[0] && q.mfe[`MPM_M_IMB];
    set[`MPM_B_JAM] = qv[2] && q.mfe[`MPM_M_JAM];
    set[`MPM_B_THDV] = qv[4] && q.sfe[`MPM_S_THDV];
    set[`MPM_B_THDI] = qv[6] && q.mfe[`MPM_M_THDI];
    set[`MPM_B_FHI] = meas.freq > q.flim[0] && q.sfe[`MPM_S_FHI];
    set[`MPM_B_FLO] = meas.freq < q.flim[1] && q.sfe[`MPM_S_FLO];
    set[`MPM_B_PMH] = q.hrs_rem == 16'h0000 && q.mfe[`MPM_M_PMH];
    set[`MPM_B_PMS] = q.sts_rem == 16'h0000 && q.mfe[`MPM_M_PMS];
    set[`MPM_B_SPH] = blocked && q.mfe[`MPM_M_SPH];
    set[`MPM_B_OG] = open_gate_trip && q.sfe[`MPM_S_OG];

    // Alarm detection, live
    al[`MPM_B_IMB] = qv[1] && q.mae[`MPM_M_IMB];
    al[`MPM_B_JAM] = qv[3] && q.mae[`MPM_M_JAM];
    al[`MPM_B_THDV] = qv[5] && q.sae[`MPM_S_THDV];
    al[`MPM_B_THDI] = qv[7] && q.mae[`MPM_M_THDI];
    al[`MPM_B_FHI] = meas.freq > q.flim[2] && q.sae[`MPM_S_FHI];
    al[`MPM_B_FLO] = meas.freq < q.flim[3] && q.sae[`MPM_S_FLO];
    al[`MPM_B_PMH] = q.hrs_rem == 16'h0000 && q.mae[`MPM_M_PMH];
    al[`MPM_B_PMS] = q.sts_rem == 16'h0000 && q.mae[`MPM_M_PMS];
    d.alarm = al;

    // Automatic restart
    rmask = 16'h0000;
    rmask[`MPM_B_OG] = q.rse[`MPM_S_OG];
    rmask[`MPM_B_FHI] = q.rse[`MPM_S_FHI];
    rmask[`MPM_B_FLO] = q.rse[`MPM_S_FHI];
    rmask[`MPM_B_THDV] = q.rse[`MPM_S_THDV];
    rs_ok = q.fault != 16'h0000 && (q.fault & ~rmask) == 16'h0000
      && {13'h0000, q.rs_cnt} < q.ratt;
    unique case (q.rs_st)
      mpm_pkg::MPM_RS_IDLE: begin
        if (rs_ok) begin
          d.rs_tmr = q.rdly;
          d.rs_st = mpm_pkg::MPM_RS_WAIT;
        end
      end
      mpm_pkg::MPM_RS_WAIT: begin
        if (q.fault == 16'h0000) begin
          d.rs_st = mpm_pkg::MPM_RS_IDLE;
        end else if (q.rs_tmr == 16'h0000) begin
          d.restart = 1'b1;
          d.rs_cnt = q.rs_cnt + 3'h1;
          clr = 16'hFFFF;
          d.rs_st = mpm_pkg::MPM_RS_IDLE;
        end else if (tick) begin
          d.rs_tmr = q.rs_tmr - 16'h0001;
        end
      end
    endcase

    // New events win over a clear in the same cycle
    d.fault = (q.fault & ~clr) | set;

    // Register reads
    if (rd) begin
      if (addr[5:4] == `MPM_A_THR_RGN) begin
        d.rdata = addr[0] ? q.dly[addr[3:1]] : q.lvl[addr[3:1]];
      end else if (addr[5:2] == `MPM_A_FLIM_RGN) begin
        d.rdata = q.flim[addr[1:0]];
      end else begin
        case (addr)
          `MPM_A_MFE: d.rdata = q.mfe;
          `MPM_A_MAE: d.rdata = q.mae;
          `MPM_A_SFE: d.rdata = q.sfe;
          `MPM_A_SAE: d.rdata = q.sae;
          `MPM_A_RSE: d.rdata = q.rse;
          `MPM_A_PMH: d.rdata = q.pmh;
          `MPM_A_PMS: d.rdata = q.pms;
          `MPM_A_SPH: d.rdata = q.sph;
          `MPM_A_RATT: d.rdata = q.ratt;
          `MPM_A_RDLY: d.rdata = q.rdly;
          `MPM_A_FAULT: d.rdata = q.fault;
          `MPM_A_ALARM: d.rdata = q.alarm;
          `MPM_A_HRS: d.rdata = q.hrs_rem;
          `MPM_A_STS: d.rdata = q.sts_rem;
          `MPM_A_RCNT: d.rdata = {12'h000, nwin};
          default: d.rdata = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign fault = q.fault;
  assign alarm = q.alarm;
  assign restart = q.restart;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  property p_imb_f;
    qv[0] && q.mfe[`MPM_M_IMB] |=> fault[`MPM_B_IMB];
  endproperty
  a_imb_f: assert property (p_imb_f) else $error("imbalance fault missed");
  property p_imb_a;
    alarm[`MPM_B_IMB] |-> $past(qv[1]) && $past(q.mae[`MPM_M_IMB]);
  endproperty
  a_imb_a: assert property (p_imb_a) else $error("imbalance alarm unqualified");
  property p_jam_f;
    $rose(fault[`MPM_B_JAM]) |-> $past(qv[2] && q.mfe[`MPM_M_JAM]);
  endproperty
  a_jam_f: assert property (p_jam_f) else $error("jam fault unqualified");
  property p_jam_a;
    !q.mae[`MPM_M_JAM] |=> !alarm[`MPM_B_JAM];
  endproperty
  a_jam_a: assert property (p_jam_a) else $error("jam alarm while disabled");
  property p_thdv_f;
    $rose(fault[`MPM_B_THDV]) |-> $past(q.sfe[`MPM_S_THDV]);
  endproperty
  a_thdv_f: assert property (p_thdv_f) else $error("distortion fault not enabled");
  property p_thdi_a;
    qv[7] && q.mae[`MPM_M_THDI] |=> alarm[`MPM_B_THDI];
  endproperty
  a_thdi_a: assert property (p_thdi_a) else $error("current distortion alarm missed");
  property p_hours;
    hour_end && q.hrs_rem != 16'h0000 && !wr
      |=> q.hrs_rem == $past(q.hrs_rem) - 16'h0001;
  endproperty
  a_hours: assert property (p_hours) else $error("hours not counted down");
  property p_sph;
    motor_start && {12'h000, nwin} >= q.sph && q.mfe[`MPM_M_SPH]
      |=> fault[`MPM_B_SPH];
  endproperty
  a_sph: assert property (p_sph) else $error("start limit fault missed");
  property p_fhi;
    meas.freq > q.flim[0] && q.sfe[`MPM_S_FHI] |=> fault[`MPM_B_FHI];
  endproperty
  a_fhi: assert property (p_fhi) else $error("high frequency fault missed");
  sequence s_arm;
    q.rs_st == mpm_pkg::MPM_RS_IDLE ##1 q.rs_st == mpm_pkg::MPM_RS_WAIT;
  endsequence
  property p_arm;
    s_arm |-> $past(rs_ok) && q.rs_tmr == $past(q.rdly);
  endproperty
  a_arm: assert property (p_arm) else $error("restart armed without cause");
  property p_fire;
    restart |-> $past(q.rs_st == mpm_pkg::MPM_RS_WAIT && q.rs_tmr == 16'h0000);
  endproperty
  a_fire: assert property (p_fire) else $error("restart before delay");
endmodule

// ===== mpm_monitor_test.sv
`timescale 1ns/1ps
module mpm_monitor_test;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic motor_running = 1'b0;
  logic motor_start = 1'b0;
  logic open_gate_trip = 1'b0;
  logic [15:0] rdata;
  logic [15:0] fault;
  logic [15:0] alarm;
  logic restart;
  mpm_pkg::mpm_meas_t meas;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  always #12.5 clock = ~clock;
  mpm_meter meter (.clock(clock), .meas(meas));
  mpm_monitor #(.TICK_CYCLES(4), .HOUR_TICKS(5)) DUT (
    .clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .meas(meas), .motor_running(motor_running),
    .motor_start(motor_start), .open_gate_trip(open_gate_trip), .fault(fault),
    .alarm(alarm), .restart(restart)
  );
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic test_done();
    if (num_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), exp, rdata);
  endtask
  task automatic pulse_start();
    @(posedge clock);
    motor_start <= 1'b1;
    @(posedge clock);
    motor_start <= 1'b0;
  endtask
  task automatic trip();
    @(posedge clock);
    open_gate_trip <= 1'b1;
    @(posedge clock);
    open_gate_trip <= 1'b0;
  endtask
  task automatic watch_restart(output int dly);
    dly = -1;
    for (int c = 0; c < 40 && dly < 0; c++) begin
      @(posedge clock);
      #1;
      if (restart === 1'b1) dly = c;
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk("fault", 16'h0000, fault);
    rd_chk(6'h01, 16'h001E);
    rd_chk(6'h02, 16'h000F);
    rd_chk(6'h04, 16'h03E8);
    rd_chk(6'h07, 16'h0001);
    rd_chk(6'h10, 16'h003F);
    rd_chk(6'h11, 16'h002F);
    rd_chk(6'h12, 16'h003F);
    rd_chk(6'h13, 16'h002F);
    rd_chk(6'h19, 16'h2710);
    rd_chk(6'h1A, 16'h0064);
    rd_chk(6'h1B, 16'h0002);
    rd_chk(6'h1D, 16'h0000);
    rd_chk(6'h3F, 16'h0000);
  endtask
  // Even channel is a fault path, odd its alarm twin
  task automatic t_chan(input int i);
    logic [5:0] en_a;
    logic [15:0] en_v;
    logic [15:0] b;
    logic is_f;
    int q;
    q = i / 2;
    is_f = (i % 2 == 0);
    en_a = (q == 2) ? (is_f ? 6'h16 : 6'h17) : (is_f ? 6'h14 : 6'h15);
    en_v = (q == 2) ? 16'h0100 : ((q == 3) ? 16'h0004 : (16'h0001 << q));
    b = 16'h0001 << q;
    wr_reg(6'(2 * i), 16'h000A);
    wr_reg(6'(2 * i + 1), 16'h0002);
    wr_reg(en_a, en_v);
    meter.put(q, 16'h000A);
    cyc(16);
    chk("level equal", 16'h0000, (fault | alarm) & b);
    meter.put(q, 16'h000B);
    cyc(5);
    chk("before delay", 16'h0000, (fault | alarm) & b);
    cyc(9);
    chk("qualified", b, (is_f ? fault : alarm) & b);
    chk("twin path", 16'h0000, (is_f ? alarm : fault) & b);
    meter.put(q, 16'h0000);
    cyc(3);
    chk("after drop", is_f ? b : 16'h0000, (is_f ? fault : alarm) & b);
    wr_reg(en_a, 16'h0000);
    wr_reg(6'h20, 16'hFFFF);
    meter.put(q, 16'h000B);
    cyc(16);
    chk("disabled", 16'h0000, (fault | alarm) & b);
    meter.put(q, 16'h0000);
    wr_reg(6'(2 * i), 16'h03E8);
  endtask
  task automatic t_freq();
    wr_reg(6'h12, 16'h003C);
    wr_reg(6'h16, 16'h0280);
    wr_reg(6'h17, 16'h0280);
    meter.put(4, 16'h003D);
    cyc(3);
    chk("alarm high", 16'h0010, alarm & 16'h0030);
    chk("fault high", 16'h0000, fault & 16'h0030);
    meter.put(4, 16'h0040);
    cyc(3);
    chk("fault high", 16'h0010, fault & 16'h0030);
    meter.put(4, 16'h002E);
    cyc(3);
    chk("alarm low", 16'h0020, alarm & 16'h0030);
    chk("fault low", 16'h0030, fault & 16'h0030);
    wr_reg(6'h16, 16'h0000);
    wr_reg(6'h17, 16'h0000);
    wr_reg(6'h20, 16'hFFFF);
    cyc(3);
    chk("fault gated", 16'h0000, fault & 16'h0030);
    chk("alarm gated", 16'h0000, alarm & 16'h0030);
    meter.put(4, 16'h0032);
  endtask
  task automatic t_starts();
    wr_reg(6'h14, 16'h0030);
    wr_reg(6'h1A, 16'h0002);
    pulse_start();
    pulse_start();
    pulse_start();
    cyc(1);
    chk("too many", 16'h0180, fault & 16'h0180);
    rd_chk(6'h23, 16'h0000);
    rd_chk(6'h24, 16'h0002);
    cyc(30);
    rd_chk(6'h24, 16'h0000);
    wr_reg(6'h14, 16'h0000);
    wr_reg(6'h20, 16'hFFFF);
  endtask
  task automatic t_hours();
    wr_reg(6'h14, 16'h0008);
    wr_reg(6'h19, 16'h0002);
    @(posedge clock);
    motor_running <= 1'b1;
    cyc(28);
    rd_chk(6'h22, 16'h0001);
    cyc(20);
    rd_chk(6'h22, 16'h0000);
    chk("hours fault", 16'h0040, fault & 16'h0040);
    wr_reg(6'h15, 16'h0008);
    cyc(2);
    chk("hours alarm", 16'h0040, alarm & 16'h0040);
    cyc(30);
    rd_chk(6'h22, 16'h0000);
    @(posedge clock);
    motor_running <= 1'b0;
    wr_reg(6'h1E, 16'h0006);
    rd_chk(6'h22, 16'h0002);
    rd_chk(6'h23, 16'h0002);
    wr_reg(6'h15, 16'h0000);
    wr_reg(6'h14, 16'h0000);
    wr_reg(6'h20, 16'hFFFF);
  endtask
  task automatic t_restart();
    int dly;
    wr_reg(6'h1E, 16'h0001);
    wr_reg(6'h1C, 16'h0002);
    wr_reg(6'h1D, 16'h0003);
    wr_reg(6'h16, 16'h0020);
    trip();
    watch_restart(dly);
    chk("not enabled", 16'hFFFF, 16'(dly));
    chk("open gate", 16'h0200, fault);
    wr_reg(6'h20, 16'hFFFF);
    wr_reg(6'h18, 16'h0020);
    for (int k = 0; k < 3; k++) begin
      trip();
      watch_restart(dly);
      chk("attempt", 16'(k < 2), 16'(dly >= 10 && dly <= 13));
      cyc(1);
      chk("fault after", (k < 2) ? 16'h0000 : 16'h0200, fault);
    end
    wr_reg(6'h20, 16'hFFFF);
    wr_reg(6'h1E, 16'h0001);
    trip();
    wr_reg(6'h20, 16'hFFFF);
    watch_restart(dly);
    chk("aborted", 16'hFFFF, 16'(dly));
    chk("fault cleared", 16'h0000, fault);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    cyc(1);
    t_reset();
    for (int i = 0; i < 8; i++) begin
      t_chan(i);
    end
    t_freq();
    t_starts();
    t_hours();
    t_restart();
    test_done();
  end
endmodule

// ===== mpm_params.svh
`ifndef MPM_PARAMS_SVH
`define MPM_PARAMS_SVH
// ****************************************
// Timing
// ****************************************
// Clock period, 25 ns
`define MPM_CLK_NS 32'h00000019
// Qualification tick, 0.1 s in ns
`define MPM_TICK_NS 32'h05F5E100
// One hour in 0.1 s ticks
`define MPM_HOUR_TICKS 32'h00008CA0
`define MPM_WIN_SLOTS 10
// ****************************************
// Register offsets
// ****************************************
`define MPM_A_THR_RGN 2'h0
`define MPM_A_FLIM_RGN 4'h4
`define MPM_A_MFE 6'h14
`define MPM_A_MAE 6'h15
`define MPM_A_SFE 6'h16
`define MPM_A_SAE 6'h17
`define MPM_A_RSE 6'h18
`define MPM_A_PMH 6'h19
`define MPM_A_PMS 6'h1A
`define MPM_A_SPH 6'h1B
`define MPM_A_RATT 6'h1C
`define MPM_A_RDLY 6'h1D
`define MPM_A_CTRL 6'h1E
`define MPM_A_FAULT 6'h20
`define MPM_A_ALARM 6'h21
`define MPM_A_HRS 6'h22
`define MPM_A_STS 6'h23
`define MPM_A_RCNT 6'h24
// ****************************************
// Reset values
// ****************************************
`define MPM_DEF_IMB_LVL 16'h000F
`define MPM_DEF_IMB_DLY 16'h001E
`define MPM_DEF_JAM_LVL 16'h03E8
`define MPM_DEF_THD_LVL 16'h03E8
`define MPM_DEF_SHORT_DLY 16'h0001
`define MPM_DEF_FHI 16'h003F
`define MPM_DEF_FLO 16'h002F
`define MPM_DEF_SFE 16'h0070
`define MPM_DEF_PMH 16'h2710
`define MPM_DEF_PMS 16'h0064
`define MPM_DEF_SPH 16'h0002
// ****************************************
// Enable and control word bits
// ****************************************
`define MPM_M_IMB 0
`define MPM_M_JAM 1
`define MPM_M_THDI 2
`define MPM_M_PMH 3
`define MPM_M_PMS 4
`define MPM_M_SPH 5
`define MPM_S_OG 5
`define MPM_S_FHI 7
`define MPM_S_THDV 8
`define MPM_S_FLO 9
`define MPM_C_RCLR 0
`define MPM_C_HLD 1
`define MPM_C_SLD 2
// ****************************************
// Fault and alarm word bits
// ****************************************
`define MPM_B_IMB 0
`define MPM_B_JAM 1
`define MPM_B_THDV 2
`define MPM_B_THDI 3
`define MPM_B_FHI 4
`define MPM_B_FLO 5
`define MPM_B_PMH 6
`define MPM_B_PMS 7
`define MPM_B_SPH 8
`define MPM_B_OG 9
`endif

// ===== mpm_pkg.sv
package mpm_pkg;
  typedef struct packed {
    logic [15:0] imbal;
    logic [15:0] peak;
    logic [15:0] thd_v;
    logic [15:0] thd_i;
    logic [15:0] freq;
  } mpm_meas_t;
  typedef enum logic [0:0] {
    MPM_RS_IDLE = 1'b0,
    MPM_RS_WAIT = 1'b1
  } mpm_rs_t;
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } mpm_tick_st_t;
  typedef struct packed {
    logic [15:0] cnt;
    logic qual;
  } mpm_qual_st_t;
  typedef struct packed {
    logic [7:0][15:0] lvl;
    logic [7:0][15:0] dly;
    logic [3:0][15:0] flim;
    logic [15:0] mfe;
    logic [15:0] mae;
    logic [15:0] sfe;
    logic [15:0] sae;
    logic [15:0] rse;
    logic [15:0] pmh;
    logic [15:0] pms;
    logic [15:0] sph;
    logic [15:0] ratt;
    logic [15:0] rdly;
    logic [15:0] fault;
    logic [15:0] alarm;
    logic [15:0] hrs_rem;
    logic [15:0] sts_rem;
    logic [15:0] run_ticks;
    logic [9:0][15:0] win;
    mpm_rs_t rs_st;
    logic [2:0] rs_cnt;
    logic [15:0] rs_tmr;
    logic [15:0] rdata;
    logic restart;
  } mpm_st_t;
endpackage

// ===== mpm_qual_timer.sv
`timescale 1ns/1ps
module mpm_qual_timer (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic tick,
  input wire logic cond,
  input wire logic [15:0] dly,
  output logic qual
);
  mpm_pkg::mpm_qual_st_t q;
  mpm_pkg::mpm_qual_st_t d;

  always_comb begin
    d = q;
    if (!cond) begin
      d.cnt = 16'h0000;
    end else if (tick && q.cnt != 16'hFFFF) begin
      d.cnt = q.cnt + 16'h0001;
    end
    d.qual = cond && (d.cnt >= dly);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign qual = q.qual;

  property p_clear;
    @(posedge clock) disable iff (!rst_b)
    !cond |=> q.cnt == 16'h0000 && !qual;
  endproperty
  a_clear: assert property (p_clear) else $error("timer kept count after drop");

  property p_need_time;
    @(posedge clock) disable iff (!rst_b)
    qual |-> $past(cond) && q.cnt >= $past(dly);
  endproperty
  a_need_time: assert property (p_need_time) else $error("qualified too early");
endmodule

// ===== mpm_tick_div.sv
`timescale 1ns/1ps
module mpm_tick_div #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic clock,
  input wire logic rst_b,
  output logic tick
);
  mpm_pkg::mpm_tick_st_t q;
  mpm_pkg::mpm_tick_st_t d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == 32'(TICK_CYCLES - 1)) begin
      d.cnt = 32'h00000000;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 32'h00000001;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

  property p_tick_gap;
    @(posedge clock) disable iff (!rst_b)
    tick |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick longer than one cycle");
endmodule
